// file: half_bridge_defs.svh
// Bit positions, reset values and timing of the half-bridge serial control
// Behaviour
// - Frame starts on chip select falling edge
// - New word applied only at chip select rise
// - Input bit sampled on serial clock fall
// - Host sends control word LSB first
// - Output driver enabled at chip select fall
// - Output bit changes on rising clock edge
// - Output high impedance while chip select high
// - Status sent LSB first, pre-warning first
// - Bit 0 clears supply, short, over-temperature flags
// - Bits 1-12 switch low/high side stages
// - Bit 13 low enables open-load detection
// - Bit 14 picks 12 ms or 1.5 ms
// - Bit 15 software enable, low is standby
// - Serial link keeps working during standby
// - Host drives hardware enable pin level
// - Fault pin pulled low on temperature/current fault
// - Status 13 short, 14 enable, 15 supply
// - Outputs off unless both enables high
// - Over-temperature shutdown reads all ones
// - Status clear re-enables short-circuited outputs
`ifndef HALF_BRIDGE_DEFS_SVH
`define HALF_BRIDGE_DEFS_SVH

`define WORD_BITS       16
`define B_CLEAR         0
`define B_SWITCH_LO     1
`define B_OL_DISABLE    13
`define B_SHORT_LONG    14
`define B_SOFT_EN       15
`define CTRL_RESET      16'hE000
`define STATUS_OT       16'hFFFF

`define CORE_PERIOD_NS  20
`define CORE_MHZ        50
`define SC_LONG_US      12000
`define SC_SHORT_US     1500
`define SCLK_PERIOD_NS  333
`define CS_SETUP_NS     150
`define CS_GAP_US       750
`define SCLK_HALF_CYC   ((`SCLK_PERIOD_NS + 2 * `CORE_PERIOD_NS - 1) / (2 * `CORE_PERIOD_NS))
`define CS_SETUP_CYC    ((`CS_SETUP_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)

`endif

// file: half_bridge_pkg.sv
// Types shared by both ends of the half-bridge serial control
package half_bridge_pkg;
	typedef logic [15:0] word_t;
	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_HIGH, H_LOW, H_HOLD, H_GAP} host_state_t;
endpackage

// file: half_bridge_if.sv
// Serial link between host and half-bridge driver, with wire resolution
`timescale 1ns/100ps
interface half_bridge_if;
	logic cs;
	logic sclk;
	logic serial_in;
	logic en;
	logic do_o;
	logic do_oe;
	logic fault_o;
	logic fault_oe;
	logic do_line;
	logic fault_line;

	// Undriven data line reads low; fault line has a pull-up
	assign do_line    = do_oe & do_o;
	assign fault_line = ~(fault_oe & ~fault_o);

	modport device (
		input  cs,
		input  sclk,
		input  serial_in,
		input  en,
		output do_o,
		output do_oe,
		output fault_o,
		output fault_oe
	);

	modport host (
		output cs,
		output sclk,
		output serial_in,
		output en,
		input  do_line,
		input  fault_line
	);
endinterface

// file: sync2.sv
// Two-flop synchroniser for a bundle of independent levels
`timescale 1ns/100ps
module sync2 #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
	input  wire logic             CLOCK,
	input  wire logic             RST,
	input  wire logic [WIDTH-1:0] D,
	output logic      [WIDTH-1:0] Q
);
	logic [WIDTH-1:0] meta_q;

	if (WIDTH < 1) begin : g_bad_width
		$error("sync2 width must be at least one");
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			meta_q <= RESET_VAL;
			Q      <= RESET_VAL;
		end else begin
			meta_q <= D;
			Q      <= meta_q;
		end
	end
endmodule

// file: half_bridge_device.sv
// Device end: serial front end, output switching and fault logic of the driver
`timescale 1ns/100ps
`include "half_bridge_defs.svh"
module half_bridge_device
	import half_bridge_pkg::*;
#(
	parameter int SC_LONG_CYC  = `SC_LONG_US * `CORE_MHZ,
	parameter int SC_SHORT_CYC = `SC_SHORT_US * `CORE_MHZ,
	parameter int CNT_W        = 20
)(
	input  wire logic        CLOCK,
	input  wire logic        RST,
	half_bridge_if.device    LINK,
	input  wire logic        OVER_TEMP,
	input  wire logic        TEMP_PREWARN,
	input  wire logic        SUPPLY_LOW,
	input  wire logic [11:0] OVER_CURRENT,
	input  wire logic [11:0] OPEN_LOAD,
	output logic      [11:0] SWITCH_ON,
	output logic             OPEN_LOAD_EN,
	output logic             SHORT_DELAY_LONG,
	output logic             ACTIVE
);
	localparam logic [CNT_W-1:0] LONG_C  = CNT_W'(SC_LONG_CYC - 1);
	localparam logic [CNT_W-1:0] SHORT_C = CNT_W'(SC_SHORT_CYC - 1);

	if (SC_SHORT_CYC < 1 || SC_LONG_CYC < 1 || SC_LONG_CYC > (1 << CNT_W)
			|| SC_SHORT_CYC > (1 << CNT_W)) begin : g_bad_delay
		$error("short-circuit delay does not fit the timer width");
	end

	// ****************************************************************
	// Link domain (serial clock; bit counter and output index cleared while chip select is high)
	// ****************************************************************
	logic [4:0]  rx_cnt_q;
	word_t       rx_q;
	word_t       word_q;
	logic        word_ok_q;
	logic [3:0]  out_idx_q;
	word_t       tx_q;

	always_ff @(negedge LINK.sclk or posedge LINK.cs) begin
		if (LINK.cs) begin
			rx_cnt_q <= 5'h00;
		end else if (rx_cnt_q != 5'h1F) begin
			rx_cnt_q <= rx_cnt_q + 5'h01;
		end
	end

	// LSB arrives first, so shift toward bit 0
	always_ff @(negedge LINK.sclk) begin
		rx_q <= {LINK.serial_in, rx_q[15:1]};
	end

	// Only a frame of exactly sixteen falling edges yields a word
	always_ff @(negedge LINK.sclk) begin
		if (rx_cnt_q == 5'h0F) begin
			word_q    <= {LINK.serial_in, rx_q[15:1]};
			word_ok_q <= 1'b1;
		end else if (rx_cnt_q == 5'h00 || rx_cnt_q[4]) begin
			word_ok_q <= 1'b0;
		end
	end

	// A rising edge shows the bit the host samples at the next fall
	always_ff @(posedge LINK.sclk or posedge LINK.cs) begin
		if (LINK.cs) begin
			out_idx_q <= 4'h0;
		end else begin
			out_idx_q <= rx_cnt_q[3:0];
		end
	end

	// Status word is frozen by the core while the frame runs
	assign LINK.do_o  = tx_q[out_idx_q];
	assign LINK.do_oe = ~LINK.cs;

	// ****************************************************************
	// Core domain synchronisers
	// ****************************************************************
	logic        cs_s;
	logic        en_s;
	logic        ot_s;
	logic        pw_s;
	logic        uv_s;
	logic [11:0] oc_s;
	logic [11:0] ol_s;

	sync2 #(
		.WIDTH     (29),
		.RESET_VAL ({1'b1, 28'h0000000})
	) u_sync (
		.CLOCK (CLOCK),
		.RST   (RST),
		.D     ({LINK.cs, LINK.en, OVER_TEMP, TEMP_PREWARN, SUPPLY_LOW,
			OVER_CURRENT, OPEN_LOAD}),
		.Q     ({cs_s, en_s, ot_s, pw_s, uv_s, oc_s, ol_s})
	);

	// ****************************************************************
	// Control word and sticky status
	// ****************************************************************
	logic        cs_prev_q;
	logic        apply;
	logic        clr;
	word_t       ctrl_q;
	logic        ot_q;
	logic        supply_fail_q;
	logic        short_flag_q;
	logic        en_eff;
	logic [11:0] sc_hit;
	logic [11:0] off_q;
	logic [11:0] sw_q;
	logic        fault_oe_q;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			cs_prev_q <= 1'b1;
		end else begin
			cs_prev_q <= cs_s;
		end
	end

	// Word and length are static once the link clock has stopped
	assign apply  = cs_s & ~cs_prev_q & word_ok_q;
	assign clr    = apply & word_q[`B_CLEAR];
	assign en_eff = ctrl_q[`B_SOFT_EN] & en_s;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ctrl_q <= `CTRL_RESET;
		end else if (apply) begin
			ctrl_q <= word_q;
		end
	end

	// Detection wins over a clear in the same cycle
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ot_q          <= 1'b0;
			supply_fail_q <= 1'b0;
			short_flag_q  <= 1'b0;
		end else begin
			ot_q          <= ot_s | (ot_q & ~clr);
			supply_fail_q <= uv_s | (supply_fail_q & ~clr);
			short_flag_q  <= (|sc_hit) | (short_flag_q & ~clr);
		end
	end

	// ****************************************************************
	// Per-stage switching and short-circuit timers
	// ****************************************************************
	for (genvar i = 0; i < 12; i++) begin : g_stage
		logic [CNT_W-1:0] tmr_q;

		assign sc_hit[i] = oc_s[i] & sw_q[i] &
			(tmr_q == (ctrl_q[`B_SHORT_LONG] ? LONG_C : SHORT_C));

		always_ff @(posedge CLOCK) begin
			if (RST || !(oc_s[i] && sw_q[i])) begin
				tmr_q <= '0;
			end else if (!sc_hit[i]) begin
				tmr_q <= tmr_q + CNT_W'(1);
			end
		end

		always_ff @(posedge CLOCK) begin
			if (RST) begin
				off_q[i] <= 1'b0;
			end else if (sc_hit[i]) begin
				off_q[i] <= 1'b1;
			end else if (clr) begin
				off_q[i] <= 1'b0;
			end
		end

		// Even index is a low side, odd index the matching high side
		always_ff @(posedge CLOCK) begin
			if (RST) begin
				sw_q[i] <= 1'b0;
			end else begin
				sw_q[i] <= ctrl_q[`B_SWITCH_LO + i] & en_eff & ~off_q[i] & ~ot_q;
			end
		end
	end

	// ****************************************************************
	// Status word, fault pin and outputs
	// ****************************************************************
	logic ol_en;
	assign ol_en = ~ctrl_q[`B_OL_DISABLE];

	// Reloaded only between frames so the shifted word never tears
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			tx_q <= '0;
		end else if (cs_s) begin
			tx_q <= ot_q ? `STATUS_OT : {supply_fail_q, en_eff, short_flag_q,
				sw_q | (ol_s & {12{ol_en}}), pw_s};
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			fault_oe_q <= 1'b0;
		end else begin
			fault_oe_q <= ot_q | short_flag_q;
		end
	end

	assign LINK.fault_o   = 1'b0;
	assign LINK.fault_oe  = fault_oe_q;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			OPEN_LOAD_EN     <= 1'b0;
			SHORT_DELAY_LONG <= 1'b0;
			ACTIVE           <= 1'b0;
		end else begin
			OPEN_LOAD_EN     <= ol_en;
			SHORT_DELAY_LONG <= ctrl_q[`B_SHORT_LONG];
			ACTIVE           <= en_eff;
		end
	end

	assign SWITCH_ON = sw_q;
endmodule

// file: half_bridge_host.sv
// Host end: frames one control word per request and returns the status word
`timescale 1ns/100ps
`include "half_bridge_defs.svh"
module half_bridge_host
	import half_bridge_pkg::*;
#(
	parameter int GAP_CYC = `CS_GAP_US * `CORE_MHZ
)(
	input  wire logic  CLOCK,
	input  wire logic  RST,
	half_bridge_if.host LINK,
	input  wire logic  START,
	input  word_t      TX_WORD,
	input  wire logic  HW_ENABLE,
	output logic       BUSY,
	output logic       DONE,
	output word_t      RX_WORD,
	output logic       FAULT
);
	localparam logic [15:0] HALF_C  = 16'(`SCLK_HALF_CYC - 1);
	localparam logic [15:0] SETUP_C = 16'(`CS_SETUP_CYC - 1);
	localparam logic [15:0] GAP_C   = 16'(GAP_CYC - 1);

	if (GAP_CYC < 1 || GAP_CYC > 65536) begin : g_bad_gap
		$error("chip select gap does not fit the timer");
	end

	host_state_t state_q;
	logic [15:0] tmr_q;
	logic [3:0]  idx_q;
	word_t       tx_q;
	word_t       rx_q;
	logic        cs_q;
	logic        sclk_q;
	logic        serial_in_q;
	logic        en_q;
	logic        do_s;
	logic        fault_s;

	sync2 #(
		.WIDTH     (2),
		.RESET_VAL (2'h3)
	) u_sync (
		.CLOCK (CLOCK),
		.RST   (RST),
		.D     ({LINK.do_line, LINK.fault_line}),
		.Q     ({do_s, fault_s})
	);

	// ****************************************************************
	// Frame sequencer; serial clock is divided from CLOCK, idle low
	// ****************************************************************
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state_q <= H_IDLE;
			tmr_q   <= 16'h0000;
			idx_q   <= 4'h0;
			tx_q    <= 16'h0000;
			rx_q    <= 16'h0000;
			cs_q    <= 1'b1;
			sclk_q  <= 1'b0;
			serial_in_q <= 1'b0;
			BUSY    <= 1'b0;
			DONE    <= 1'b0;
			RX_WORD <= 16'h0000;
		end else begin
			DONE <= 1'b0;
			case (state_q)
				H_IDLE: begin
					if (START) begin
						tx_q    <= TX_WORD;
						serial_in_q <= TX_WORD[0];
						cs_q    <= 1'b0;
						idx_q   <= 4'h0;
						BUSY    <= 1'b1;
						tmr_q   <= SETUP_C;
						state_q <= H_SETUP;
					end
				end
				H_SETUP: begin
					if (tmr_q == 16'h0000) begin
						sclk_q  <= 1'b1;
						tmr_q   <= HALF_C;
						state_q <= H_HIGH;
					end else begin
						tmr_q <= tmr_q - 16'h0001;
					end
				end
				H_HIGH: begin
					if (tmr_q == 16'h0000) begin
						rx_q[idx_q] <= do_s;
						sclk_q      <= 1'b0;
						tmr_q       <= HALF_C;
						state_q     <= H_LOW;
					end else begin
						tmr_q <= tmr_q - 16'h0001;
					end
				end
				H_LOW: begin
					if (tmr_q != 16'h0000) begin
						tmr_q <= tmr_q - 16'h0001;
					end else if (idx_q == 4'hF) begin
						tmr_q   <= SETUP_C;
						state_q <= H_HOLD;
					end else begin
						idx_q   <= idx_q + 4'h1;
						serial_in_q <= tx_q[idx_q + 4'h1];
						sclk_q  <= 1'b1;
						tmr_q   <= HALF_C;
						state_q <= H_HIGH;
					end
				end
				H_HOLD: begin
					if (tmr_q == 16'h0000) begin
						cs_q    <= 1'b1;
						RX_WORD <= rx_q;
						DONE    <= 1'b1;
						tmr_q   <= GAP_C;
						state_q <= H_GAP;
					end else begin
						tmr_q <= tmr_q - 16'h0001;
					end
				end
				H_GAP: begin
					if (tmr_q == 16'h0000) begin
						BUSY    <= 1'b0;
						state_q <= H_IDLE;
					end else begin
						tmr_q <= tmr_q - 16'h0001;
					end
				end
				default: begin
					state_q <= H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			en_q  <= 1'b0;
			FAULT <= 1'b0;
		end else begin
			en_q  <= HW_ENABLE;
			FAULT <= ~fault_s;
		end
	end

	assign LINK.cs        = cs_q;
	assign LINK.sclk      = sclk_q;
	assign LINK.serial_in = serial_in_q;
	assign LINK.en        = en_q;
endmodule

// file: half_bridge_monitor.sv
// Concurrent checks on the serial link between host and device ends
`timescale 1ns/100ps
module half_bridge_monitor (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic cs,
	input wire logic sclk,
	input wire logic serial_in,
	input wire logic do_o,
	input wire logic do_oe,
	input wire logic fault_o,
	input wire logic fault_oe,
	input wire logic do_line,
	input wire logic fault_line
);
	logic [4:0] rises_q;

	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);

	// Serial clock rises seen in the current frame
	always_ff @(posedge CLOCK) begin
		if (RST || cs) begin
			rises_q <= 5'h00;
		end else if ($rose(sclk)) begin
			rises_q <= rises_q + 5'h01;
		end
	end

	// ****************************************
	// Link checks
	// ****************************************
	chk_oe_tracks_cs: assert property (do_oe != cs)
		else $error("data driver enable does not follow chip select");
	chk_idle_line_low: assert property (cs |-> !do_line)
		else $error("data line driven while deselected");
	// Snapshot settles a few cycles after chip select falls
	chk_do_holds: assert property (!cs && !$past(cs, 4) && !$rose(sclk) |-> $stable(do_o))
		else $error("data out changed away from a rising clock");
	chk_di_steady: assert property ($fell(sclk) |-> $stable(serial_in))
		else $error("data in moved at the sampling edge");
	chk_cs_setup: assert property ($fell(cs) |-> !sclk [*8])
		else $error("serial clock too soon after chip select fall");
	chk_sclk_idle: assert property (cs |-> !sclk)
		else $error("serial clock toggles outside a frame");
	chk_sixteen_rises: assert property ($rose(cs) |-> rises_q == 5'h10)
		else $error("frame did not carry sixteen clocks");
	chk_fault_opendrain: assert property (!fault_o && fault_line == !fault_oe)
		else $error("fault pin is not open drain");
	cover property ($rose(cs) && rises_q == 5'h10);
	cover property ($rose(fault_oe));
	cover property (!cs && do_line);
endmodule

// file: testbench.sv
// Self-checking bench: host and device ends joined over one serial link
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
	$display("mismatch t=%0t got %h want %h", $time, (a), (e)); end end
module testbench;
	import half_bridge_pkg::*;
	logic        CLOCK = 1'b0;
	logic        RST   = 1'b1;
	logic        start = 1'b0;
	word_t       tx    = 16'h0000;
	logic        hw_en = 1'b0;
	logic        ot    = 1'b0;
	logic        warn  = 1'b0;
	logic        low_v = 1'b0;
	logic [11:0] oc    = 12'h000;
	logic [11:0] ol    = 12'h000;
	logic [11:0] sw_on;
	logic        ol_en, sd_long, active, busy, done, fault;
	word_t       rx;
	int          failures = 0;
	int          checked  = 0;
	int          cycles   = 0;

	half_bridge_if link ();

	// Short counts keep the fault timing scenarios brief
	half_bridge_host #(.GAP_CYC(20)) i_half_bridge_host (
		.CLOCK(CLOCK), .RST(RST), .LINK(link.host), .START(start), .TX_WORD(tx),
		.HW_ENABLE(hw_en), .BUSY(busy), .DONE(done), .RX_WORD(rx), .FAULT(fault));
	half_bridge_device #(.SC_LONG_CYC(40), .SC_SHORT_CYC(10)) i_half_bridge_device (
		.CLOCK(CLOCK), .RST(RST), .LINK(link.device), .OVER_TEMP(ot), .TEMP_PREWARN(warn),
		.SUPPLY_LOW(low_v), .OVER_CURRENT(oc), .OPEN_LOAD(ol), .SWITCH_ON(sw_on),
		.OPEN_LOAD_EN(ol_en), .SHORT_DELAY_LONG(sd_long), .ACTIVE(active));
	half_bridge_monitor i_half_bridge_monitor (
		.CLOCK(CLOCK), .RST(RST), .cs(link.cs), .sclk(link.sclk), .serial_in(link.serial_in),
		.do_o(link.do_o), .do_oe(link.do_oe), .fault_o(link.fault_o),
		.fault_oe(link.fault_oe), .do_line(link.do_line), .fault_line(link.fault_line));

	always #10 CLOCK = ~CLOCK;

	// ****************************************
	// Tasks
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Sends one word, compares the returned status, waits out the gap
	task automatic frame(input word_t w, input word_t s);
		int i;
		tick(1);
		start = 1'b1;
		tx    = w;
		tick(1);
		start = 1'b0;
		for (i = 0; i < 400 && done !== 1'b1; i++) tick(1);
		`CHK(rx, s)
		for (i = 0; i < 100 && busy !== 1'b0; i++) tick(1);
		tick(4);
		$display("frame %h done", w);
	endtask

	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 8000) begin
			failures++;
			tally_and_finish();
		end
	end

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		tick(20);
		RST = 1'b0;
		tick(3);
		`CHK(sw_on, 12'h000)
		`CHK(active, 1'b0)
		`CHK(sd_long, 1'b1)
		`CHK(ol_en, 1'b0)
		hw_en = 1'b1;
		tick(8);
		`CHK(active, 1'b1)
		frame(16'hAAAA, 16'h4000);
		`CHK(sw_on, 12'h555)
		`CHK(sd_long, 1'b0)
		frame(16'h5554, 16'h4AAA);
		`CHK(active, 1'b0)
		`CHK(sw_on, 12'h000)
		`CHK(ol_en, 1'b1)
		warn  = 1'b1;
		low_v = 1'b1;
		ol    = 12'h00F;
		frame(16'hA002, 16'h801F);
		`CHK(sw_on, 12'h001)
		warn  = 1'b0;
		low_v = 1'b0;
		ol    = 12'h000;
		oc    = 12'h001;
		tick(5);
		`CHK(sw_on, 12'h001)
		tick(25);
		`CHK(sw_on, 12'h000)
		`CHK(fault, 1'b1)
		oc = 12'h000;
		frame(16'hA003, 16'hE000);
		`CHK(sw_on, 12'h001)
		`CHK(fault, 1'b0)
		ot = 1'b1;
		tick(3);
		ot = 1'b0;
		frame(16'hA000, 16'hFFFF);
		`CHK(fault, 1'b1)
		frame(16'hA001, 16'hFFFF);
		`CHK(fault, 1'b0)
		frame(16'hA000, 16'h4000);
		frame(16'hE002, 16'h4000);
		`CHK(sd_long, 1'b1)
		`CHK(sw_on, 12'h001)
		oc = 12'h001;
		tick(30);
		`CHK(sw_on, 12'h001)
		tick(20);
		`CHK(sw_on, 12'h000)
		`CHK(fault, 1'b1)
		oc = 12'h000;
		hw_en = 1'b0;
		tick(8);
		`CHK(active, 1'b0)
		tally_and_finish();
	end
endmodule
